//--- src/ubet_hub_end.sv
`timescale 1ns/100ps
// How it works
// - connect seen after 2.5 us of non-SE0
// - disconnect reported after 2 us of SE0
// - downstream resume driven for 20 ms
// - downstream resume rebroadcast after 2.5 us filter
// - port reset driven for 12 ms
// - root hub repeats reset, 1 ms gaps
// - long upstream K detected after 2.5 us
// - long upstream SE0 detected after 2.5 us
// - repeated SE0 cut after 23 FS bits
// - optional post-EOF1 SE0 at most 2 bits
// - high-speed response late after 192 bits
// - chirps accepted only after 2.5 us filter
// - hub chirp starts right after device chirp
// - each hub chirp lasts 50 us
// - chirps end 200-300 us before reset end
// - device attaches once power is good
// - device suspends after 3 ms idle
// - remote wakeup needs enable and 5 ms idle
// - device drives upstream resume for 2 ms
// - device sees reset after 2.5 us SE0 unless in high-speed mode
// - full-speed gap and response deadlines kept
module ubet_hub_end #(
  parameter ubet_pkg::ubet_cnt_t P_RSMDN    = ubet_pkg::RSMDN_CYC,
  parameter ubet_pkg::ubet_cnt_t P_RST      = ubet_pkg::RST_CYC,
  parameter ubet_pkg::ubet_cnt_t P_ROOT_GAP = ubet_pkg::ROOT_GAP_CYC,
  parameter ubet_pkg::ubet_cnt_t P_CHSE0    = ubet_pkg::CHSE0_CYC
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire logic                ce,
  // link to the attached device
  ubet_link_if.hub                 link,
  // port control
  input  wire logic                portReset,
  input  wire logic                resumeReq,
  input  wire logic                rootHub,
  output logic                     resetActive,
  output logic                     hsMode,
  // downstream port status
  output logic                     connected,
  output logic                     discEvt,
  output logic                     rsmRebroadcast,
  // upstream line and repeater
  input  wire ubet_pkg::ubet_line_e upLine,
  input  wire logic                eof1,
  input  wire logic                eofSe0En,
  output logic                     longK,
  output logic                     longSe0,
  output logic                     upSe0Rep,
  output logic                     upSe0Eof,
  // packet timing
  input  wire logic                txReq,
  input  wire logic                txActive,
  output logic                     txGo,
  output logic                     respLate
);
  import ubet_pkg::*;
  ubet_hub_st_e st, next_st;
  ubet_chirp_e  cst, next_cst;
  ubet_cnt_t    stCnt, next_stCnt, chCnt, next_chCnt;
  ubet_cnt_t    repCnt, next_repCnt, eofCnt, next_eofCnt, gap, next_gap;
  logic [2:0]   seg, next_seg;
  logic         chK, next_chK, next_hsMode;
  logic         next_connected, next_discEvt, next_upSe0Rep;
  logic         lastOwn, next_lastOwn, respPend, next_respPend, next_respLate;
  logic         connHit, discHit, devKHit, rsmHit;
  logic         hubDrives, lineSe0;

  assign hubDrives = (st == H_RESUME || st == H_RESET);
  assign lineSe0   = (link.busLine == LINE_SE0);

  ubet_filter #(.LIMIT(FILT_CYC)) u_conn (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(!hubDrives && !lineSe0), .hit(connHit));
  ubet_filter #(.LIMIT(DISC_CYC)) u_disc (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(!hubDrives && lineSe0), .hit(discHit));
  ubet_filter #(.LIMIT(FILT_CYC)) u_devk (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(st == H_RESET && cst == C_WAIT && link.busLine == LINE_K), .hit(devKHit));
  ubet_filter #(.LIMIT(FILT_CYC)) u_rsm (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(st == H_IDLE && connected && link.busLine == LINE_K), .hit(rsmHit));
  ubet_filter #(.LIMIT(FILT_CYC)) u_lk (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(upLine == LINE_K), .hit(longK));
  ubet_filter #(.LIMIT(FILT_CYC)) u_lse0 (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(upLine == LINE_SE0), .hit(longSe0));

  // port sequencing: resume, reset segments and the chirp handshake
  always_comb begin
    next_st     = st;
    next_stCnt  = stCnt + 24'h000001;
    next_seg    = seg;
    next_cst    = cst;
    next_chCnt  = chCnt + 24'h000001;
    next_chK    = chK;
    next_hsMode = hsMode;
    unique case (st)
      H_IDLE: begin
        next_stCnt = '0;
        if (portReset) begin
          next_st     = H_RESET;
          next_seg    = 3'h0;
          next_cst    = C_WAIT;
          next_hsMode = 1'b0;
        end else if (resumeReq) begin
          next_st = H_RESUME;
        end
      end
      H_RESUME: begin
        if (stCnt == P_RSMDN - 24'h000001) next_st = H_IDLE;
      end
      H_RESET: begin
        if (stCnt == P_RST - 24'h000001) begin
          next_stCnt = '0;
          if (rootHub && seg != ROOT_SEGS - 3'h1) next_st = H_GAP;
          else next_st = H_IDLE;
        end
      end
      H_GAP: begin
        if (stCnt == P_ROOT_GAP - 24'h000001) begin
          next_st    = H_RESET;
          next_stCnt = '0;
          next_seg   = seg + 3'h1;
          next_cst   = C_WAIT;
        end
      end
    endcase
    if (st == H_RESET) begin
      unique case (cst)
        C_WAIT: begin
          if (devKHit) next_cst = C_DEVK;
        end
        C_DEVK: begin
          if (link.busLine != LINE_K) begin
            next_cst   = C_HUB;
            next_chCnt = '0;
            next_chK   = 1'b1;
          end
        end
        C_HUB: begin
          if (chCnt == CHIRP_CYC - 24'h000001) begin
            next_chCnt = '0;
            next_chK   = !chK;
            // stop on a whole pair if another pair would eat into the SE0 tail
            if (!chK && stCnt + CHIRP_PAIR_CYC + P_CHSE0 >= P_RST) begin
              next_cst    = C_DONE;
              next_hsMode = 1'b1;
            end
          end
        end
        C_DONE: begin
          next_chCnt = chCnt;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st     <= H_IDLE;
      cst    <= C_WAIT;
      stCnt  <= '0;
      chCnt  <= '0;
      seg    <= 3'h0;
      chK    <= 1'b0;
      hsMode <= 1'b0;
    end else if (ce) begin
      st     <= next_st;
      cst    <= next_cst;
      stCnt  <= next_stCnt;
      chCnt  <= next_chCnt;
      seg    <= next_seg;
      chK    <= next_chK;
      hsMode <= next_hsMode;
    end
  end

  // port status and repeater SE0 limits
  always_comb begin
    next_connected = connected;
    next_discEvt   = 1'b0;
    if (discHit && connected) begin
      next_connected = 1'b0;
      next_discEvt   = 1'b1;
    end else if (connHit) begin
      next_connected = 1'b1;
    end
    next_repCnt = '0;
    if (st == H_IDLE && lineSe0 && repCnt != REP_SE0_CYC) next_repCnt = repCnt + 24'h000001;
    else if (st == H_IDLE && lineSe0) next_repCnt = repCnt;
    next_upSe0Rep = (st == H_IDLE && lineSe0 && repCnt != REP_SE0_CYC);
    next_eofCnt   = eofCnt;
    if (eofCnt != '0) next_eofCnt = eofCnt - 24'h000001;
    else if (eof1 && eofSe0En) next_eofCnt = EOF_SE0_CYC;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      connected <= 1'b0;
      discEvt   <= 1'b0;
      repCnt    <= '0;
      upSe0Rep  <= 1'b0;
      eofCnt    <= '0;
    end else if (ce) begin
      connected <= next_connected;
      discEvt   <= next_discEvt;
      repCnt    <= next_repCnt;
      upSe0Rep  <= next_upSe0Rep;
      eofCnt    <= next_eofCnt;
    end
  end

  // inter-packet gap and root hub response deadline
  always_comb begin
    next_gap      = (gap == GAP_SAT) ? gap : gap + 24'h000001;
    next_lastOwn  = lastOwn;
    next_respPend = respPend;
    next_respLate = 1'b0;
    if (txActive || link.devPkt) next_gap = '0;
    if (txActive) next_lastOwn = 1'b1;
    else if (link.devPkt) next_lastOwn = 1'b0;
    if (link.devPkt) begin
      next_respPend = rootHub && hsMode;
    end else if (txActive) begin
      next_respPend = 1'b0;
    end else if (respPend && gap == HS_RSP_CYC) begin
      next_respPend = 1'b0;
      next_respLate = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap      <= GAP_SAT;
      lastOwn  <= 1'b0;
      respPend <= 1'b0;
      respLate <= 1'b0;
    end else if (ce) begin
      gap      <= next_gap;
      lastOwn  <= next_lastOwn;
      respPend <= next_respPend;
      respLate <= next_respLate;
    end
  end

  assign txGo             = txReq && !link.devPkt && ubetGapOk(hsMode, lastOwn, gap);
  assign upSe0Eof         = (eofCnt != '0);
  assign rsmRebroadcast   = rsmHit;
  assign resetActive      = (st == H_RESET || st == H_GAP);
  assign link.hubLineOe_n = !hubDrives;
  assign link.hubLine     = (st == H_RESUME) ? LINE_K :
                            (cst == C_HUB)   ? (chK ? LINE_K : LINE_J) : LINE_SE0;
  assign link.hubPkt      = txActive;
endmodule : ubet_hub_end

//--- include/ubet_pkg.sv
package ubet_pkg;

  typedef logic [23:0] ubet_cnt_t;

  typedef enum logic [1:0] {
    LINE_SE0 = 2'b00,
    LINE_J   = 2'b01,
    LINE_K   = 2'b10,
    LINE_SE1 = 2'b11
  } ubet_line_e;

  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_RESUME = 2'b01,
    H_RESET  = 2'b10,
    H_GAP    = 2'b11
  } ubet_hub_st_e;

  typedef enum logic [1:0] {
    C_WAIT = 2'b00,
    C_DEVK = 2'b01,
    C_HUB  = 2'b10,
    C_DONE = 2'b11
  } ubet_chirp_e;

  typedef enum logic [2:0] {
    D_OFF    = 3'b000,
    D_IDLE   = 3'b001,
    D_CHIRP  = 3'b010,
    D_LISTEN = 3'b011,
    D_RESUME = 3'b100
  } ubet_dev_st_e;

  localparam longint CLK_PS    = 25000;
  localparam longint FS_BIT_PS = 83333;
  localparam longint HS_BIT_PS = 2083;
  localparam longint NS_PS     = 1000;
  localparam longint US_PS     = 1000000;
  localparam longint MS_PS     = 1000000000;

  // least times round up, longest times round down, never below one cycle
  function automatic ubet_cnt_t ubetCycMin(input longint ps);
    longint c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    if (c < 1) c = 1;
    return c[23:0];
  endfunction : ubetCycMin

  function automatic ubet_cnt_t ubetCycMax(input longint ps);
    longint c;
    c = ps / CLK_PS;
    if (c < 1) c = 1;
    return c[23:0];
  endfunction : ubetCycMax

  localparam longint T_FILT_NS      = 2500;
  localparam longint T_DISC_NS      = 2000;
  localparam longint T_RSMDN_MS     = 20;
  localparam longint T_DRST_MS      = 12;
  localparam longint T_ROOT_GAP_MS  = 1;
  localparam longint T_CHIRP_US     = 50;
  localparam longint T_CHSE0_US     = 200;
  localparam longint T_DCHIRP_MS    = 1;
  localparam longint T_WTFS_MS      = 2;
  localparam longint T_SUSP_MS      = 3;
  localparam longint T_WTRSM_MS     = 5;
  localparam longint T_DRSMUP_MS    = 2;
  localparam longint REP_SE0_BITS   = 23;
  localparam longint EOF_SE0_BITS   = 2;
  localparam longint HS_SD_BITS     = 88;
  localparam longint HS_OD_BITS     = 8;
  localparam longint HS_RSP_BITS    = 192;
  localparam longint LFS_IPD_BITS   = 2;
  localparam longint RSP_DET_BITS10 = 65;
  localparam longint RSP_CAP_BITS10 = 75;

  localparam ubet_cnt_t FILT_CYC       = ubetCycMin(T_FILT_NS * NS_PS);
  localparam ubet_cnt_t DISC_CYC       = ubetCycMin(T_DISC_NS * NS_PS);
  localparam ubet_cnt_t RSMDN_CYC      = ubetCycMin(T_RSMDN_MS * MS_PS);
  localparam ubet_cnt_t RST_CYC        = ubetCycMin(T_DRST_MS * MS_PS);
  localparam ubet_cnt_t ROOT_GAP_CYC   = ubetCycMax(T_ROOT_GAP_MS * MS_PS);
  localparam logic [2:0] ROOT_SEGS     = 3'h5;
  localparam ubet_cnt_t CHIRP_CYC      = ubetCycMin(T_CHIRP_US * US_PS);
  localparam ubet_cnt_t CHIRP_PAIR_CYC = ubetCycMin(2 * T_CHIRP_US * US_PS);
  localparam ubet_cnt_t CHSE0_CYC      = ubetCycMin(T_CHSE0_US * US_PS);
  localparam ubet_cnt_t DCHIRP_CYC     = ubetCycMin(T_DCHIRP_MS * MS_PS);
  localparam ubet_cnt_t WTFS_CYC       = ubetCycMax(T_WTFS_MS * MS_PS);
  localparam ubet_cnt_t SUSP_CYC       = ubetCycMin(T_SUSP_MS * MS_PS);
  localparam ubet_cnt_t WTRSM_CYC      = ubetCycMin(T_WTRSM_MS * MS_PS);
  localparam ubet_cnt_t DRSMUP_CYC     = ubetCycMin(T_DRSMUP_MS * MS_PS);
  localparam ubet_cnt_t REP_SE0_CYC    = ubetCycMax(REP_SE0_BITS * FS_BIT_PS);
  localparam ubet_cnt_t EOF_SE0_CYC    = ubetCycMax(EOF_SE0_BITS * FS_BIT_PS);
  localparam ubet_cnt_t HS_SD_CYC      = ubetCycMin(HS_SD_BITS * HS_BIT_PS);
  localparam ubet_cnt_t HS_OD_CYC      = ubetCycMin(HS_OD_BITS * HS_BIT_PS);
  localparam ubet_cnt_t HS_RSP_CYC     = ubetCycMax(HS_RSP_BITS * HS_BIT_PS);
  localparam ubet_cnt_t LFS_IPD_CYC    = ubetCycMin(LFS_IPD_BITS * FS_BIT_PS);
  localparam ubet_cnt_t RSP_DET_CYC    = ubetCycMax(RSP_DET_BITS10 * FS_BIT_PS / 10);
  localparam ubet_cnt_t RSP_CAP_CYC    = ubetCycMax(RSP_CAP_BITS10 * FS_BIT_PS / 10);
  localparam ubet_cnt_t GAP_SAT        = 24'h0000ff;

  // same direction means the previous packet was our own
  function automatic logic ubetGapOk(input logic hs, input logic same, input ubet_cnt_t gap);
    if (hs) return same ? (gap >= HS_SD_CYC) : (gap >= HS_OD_CYC);
    return gap >= LFS_IPD_CYC;
  endfunction : ubetGapOk

endpackage : ubet_pkg

//--- include/ubet_link_if.sv
`timescale 1ns/100ps
interface ubet_link_if;
  import ubet_pkg::*;
  ubet_line_e hubLine;
  logic       hubLineOe_n;
  logic       hubPkt;
  ubet_line_e devLine;
  logic       devLineOe_n;
  logic       devPkt;
  logic       devAttach;
  ubet_line_e busLine;

  // device drive wins so its chirp K shows through the hub's reset SE0
  assign busLine = !devLineOe_n ? devLine :
                   !hubLineOe_n ? hubLine :
                   devAttach    ? LINE_J : LINE_SE0;

  modport hub (output hubLine, hubLineOe_n, hubPkt, input devPkt, busLine);
  modport dev (output devLine, devLineOe_n, devPkt, devAttach, input hubPkt, busLine);
endinterface : ubet_link_if

//--- src/ubet_filter.sv
`timescale 1ns/100ps
module ubet_filter #(
  parameter ubet_pkg::ubet_cnt_t LIMIT = ubet_pkg::FILT_CYC
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic ce,
  // watched condition
  input  wire logic cond,
  output logic      hit
);
  import ubet_pkg::*;
  ubet_cnt_t cnt;
  ubet_cnt_t next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (!cond) begin
      next_cnt = '0;
    end else if (cnt != LIMIT) begin
      next_cnt = cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (ce) begin
      cnt <= next_cnt;
    end
  end

  assign hit = (cnt == LIMIT);
endmodule : ubet_filter

//--- src/ubet_dev_end.sv
`timescale 1ns/100ps
module ubet_dev_end #(
  parameter ubet_pkg::ubet_cnt_t P_DCHIRP = ubet_pkg::DCHIRP_CYC,
  parameter ubet_pkg::ubet_cnt_t P_WTFS   = ubet_pkg::WTFS_CYC,
  parameter ubet_pkg::ubet_cnt_t P_SUSP   = ubet_pkg::SUSP_CYC,
  parameter ubet_pkg::ubet_cnt_t P_WTRSM  = ubet_pkg::WTRSM_CYC,
  parameter ubet_pkg::ubet_cnt_t P_DRSMUP = ubet_pkg::DRSMUP_CYC
) (
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  input  wire logic  ce,
  // link to the hub
  ubet_link_if.dev   link,
  // device control
  input  wire logic  powerGood,
  input  wire logic  hsCap,
  input  wire logic  rwEn,
  input  wire logic  wakeReq,
  input  wire logic  captive,
  output logic       attached,
  output logic       suspend,
  output logic       resetSeen,
  output logic       hsMode,
  output logic       resuming,
  // packet timing
  input  wire logic  txReq,
  input  wire logic  txActive,
  output logic       txGo,
  output logic       respLate
);
  import ubet_pkg::*;
  ubet_dev_st_e st, next_st;
  ubet_cnt_t    cnt, next_cnt, gap, next_gap;
  logic [2:0]   nCh, next_nCh;
  logic         lastK, next_lastK, rstArm, next_rstArm;
  logic         next_hsMode, next_resetSeen, lastOwn, next_lastOwn;
  logic         respPend, next_respPend, next_respLate;
  logic         rstHit, suspHit, wakeHit, kHit, jHit;

  ubet_filter #(.LIMIT(FILT_CYC)) u_rst (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(st == D_IDLE && rstArm && link.busLine == LINE_SE0), .hit(rstHit));
  ubet_filter #(.LIMIT(P_SUSP)) u_susp (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(st == D_IDLE && link.busLine == LINE_J && !link.hubPkt), .hit(suspHit));
  ubet_filter #(.LIMIT(P_WTRSM)) u_wake (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(st == D_IDLE && link.busLine == LINE_J && !link.hubPkt), .hit(wakeHit));
  ubet_filter #(.LIMIT(FILT_CYC)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(st == D_LISTEN && link.busLine == LINE_K), .hit(kHit));
  ubet_filter #(.LIMIT(FILT_CYC)) u_chj (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .cond(st == D_LISTEN && link.busLine == LINE_J), .hit(jHit));

  always_comb begin
    next_st        = st;
    next_cnt       = cnt + 24'h000001;
    next_nCh       = nCh;
    next_lastK     = lastK;
    next_hsMode    = hsMode;
    next_resetSeen = 1'b0;
    // a reset is re-armed only once the line has left SE0 while idle at full speed;
    // hub chirps after the handshake and the closing SE0 tail must not re-trigger it
    next_rstArm    = rstArm | (link.busLine != LINE_SE0 && st == D_IDLE && !hsMode);
    unique case (st)
      D_OFF: begin
        if (powerGood) next_st = D_IDLE;
      end
      D_IDLE: begin
        next_cnt = '0;
        if (rstHit) begin
          next_resetSeen = 1'b1;
          next_rstArm    = 1'b0;
          next_hsMode    = 1'b0;
          if (hsCap) next_st = D_CHIRP;
        end else if (wakeReq && rwEn && wakeHit) begin
          next_st = D_RESUME;
        end
      end
      D_CHIRP: begin
        if (cnt == P_DCHIRP - 24'h000001) begin
          next_st  = D_LISTEN;
          next_cnt = '0;
          next_nCh = 3'h0;
        end
      end
      D_LISTEN: begin
        if ((kHit && (!lastK || nCh == 3'h0)) || (jHit && lastK && nCh != 3'h0)) begin
          next_nCh   = nCh + 3'h1;
          next_lastK = kHit;
        end
        if (nCh == 3'h6) begin
          next_hsMode = 1'b1;
          next_st     = D_IDLE;
        end else if (nCh == 3'h0 && cnt == P_WTFS - 24'h000001) begin
          next_st = D_IDLE;
        end
      end
      D_RESUME: begin
        if (cnt == P_DRSMUP - 24'h000001) next_st = D_IDLE;
      end
      default: next_st = D_OFF;
    endcase
    if (!powerGood) next_st = D_OFF;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st        <= D_OFF;
      cnt       <= '0;
      nCh       <= 3'h0;
      lastK     <= 1'b0;
      hsMode    <= 1'b0;
      resetSeen <= 1'b0;
      rstArm    <= 1'b0;
    end else if (ce) begin
      st        <= next_st;
      cnt       <= next_cnt;
      nCh       <= next_nCh;
      lastK     <= next_lastK;
      hsMode    <= next_hsMode;
      resetSeen <= next_resetSeen;
      rstArm    <= next_rstArm;
    end
  end

  always_comb begin
    next_gap      = (gap == GAP_SAT) ? gap : gap + 24'h000001;
    next_lastOwn  = lastOwn;
    next_respPend = respPend;
    next_respLate = 1'b0;
    if (txActive || link.hubPkt) next_gap = '0;
    if (txActive) next_lastOwn = 1'b1;
    else if (link.hubPkt) next_lastOwn = 1'b0;
    if (link.hubPkt) begin
      next_respPend = 1'b1;
    end else if (txActive) begin
      next_respPend = 1'b0;
    end else if (respPend && gap == (hsMode ? HS_RSP_CYC : (captive ? RSP_CAP_CYC : RSP_DET_CYC))) begin
      next_respPend = 1'b0;
      next_respLate = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap      <= GAP_SAT;
      lastOwn  <= 1'b0;
      respPend <= 1'b0;
      respLate <= 1'b0;
    end else if (ce) begin
      gap      <= next_gap;
      lastOwn  <= next_lastOwn;
      respPend <= next_respPend;
      respLate <= next_respLate;
    end
  end

  assign txGo             = txReq && !link.hubPkt && ubetGapOk(hsMode, lastOwn, gap);
  assign attached         = (st != D_OFF);
  assign suspend          = suspHit;
  assign resuming         = (st == D_RESUME);
  assign link.devAttach   = attached;
  assign link.devLine     = LINE_K;
  assign link.devLineOe_n = !(st == D_CHIRP || st == D_RESUME);
  assign link.devPkt      = txActive;
endmodule : ubet_dev_end

//--- testbench/ubet_link_sva.sv
`timescale 1ns/100ps
module ubet_link_sva
  import ubet_pkg::*;
#(
  parameter ubet_cnt_t P_RST   = RST_CYC,
  parameter ubet_cnt_t P_RSMDN = RSMDN_CYC
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       arst_n,
  // link wires
  input wire ubet_line_e hubLine,
  input wire logic       hubLineOe_n,
  input wire ubet_line_e devLine,
  input wire logic       devLineOe_n,
  input wire logic       devAttach
);
  ubet_line_e lastLine;
  ubet_cnt_t  hubDrv;
  ubet_cnt_t  segCnt;
  // a run of n cycles reads n-1 here: its first cycle only clears the count
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lastLine <= LINE_SE0;
      hubDrv   <= 24'h000000;
      segCnt   <= 24'h000000;
    end else begin
      lastLine <= hubLine;
      hubDrv   <= hubLineOe_n ? 24'h000000 : hubDrv + 24'h000001;
      segCnt   <= (!hubLineOe_n && hubLine == lastLine) ? segCnt + 24'h000001 : 24'h000000;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence devChirpEnd;
    $rose(devLineOe_n) && !hubLineOe_n;
  endsequence
  sequence hubChirpK;
    !hubLineOe_n && hubLine == LINE_K;
  endsequence
  chk_drive_start: assert property ($fell(hubLineOe_n) |-> hubLine inside {LINE_SE0, LINE_K})
    else $error("hub drive opened with a bad state");
  chk_no_se1: assert property (!hubLineOe_n |-> hubLine != LINE_SE1)
    else $error("hub drove SE1");
  chk_drive_len: assert property ($rose(hubLineOe_n)
    |-> hubDrv inside {[P_RST-2:P_RST+1], [P_RSMDN-2:P_RSMDN+1]}) else $error("hub drive length off");
  chk_chirp_len: assert property (!hubLineOe_n && !$past(hubLineOe_n) && hubLine != lastLine
    && hubLine != LINE_SE0 && lastLine != LINE_SE0 |-> segCnt inside {[CHIRP_CYC-2:CHIRP_CYC+1]})
    else $error("hub chirp length off");
  chk_chirp_reply: assert property (devChirpEnd |-> ##[0:1000] hubChirpK)
    else $error("hub chirp K late");
  chk_tail_se0: assert property ($rose(hubLineOe_n) && lastLine == LINE_SE0
    |-> segCnt inside {[3999:20000]}) else $error("reset tail length off");
  chk_dev_attach: assert property (!devLineOe_n |-> devAttach)
    else $error("device drove while detached");
  chk_dev_k: assert property (!devLineOe_n |-> devLine == LINE_K)
    else $error("device drove a state other than K");
endmodule : ubet_link_sva

//--- testbench/usb_bus_event_timers_tb.sv
`timescale 1ns/100ps
module usb_bus_event_timers_tb;
  import ubet_pkg::*;
  logic clk_sys, arst_n, portReset, resumeReq, eof1, eofSe0En, hTxReq, hTxAct, powerGood, hsCap, rwEn, wakeReq;
  logic dTxAct, resetActive, hHs, connected, discEvt, rsmRb, longK, longSe0, upSe0Rep, upSe0Eof, hTxGo;
  logic attached, suspend, resetSeen, dHs, resuming, dLate, ce, rootHub, captive, dTxReq;
  // reset sized so three chirp pairs fit before the default SE0 tail
  localparam ubet_cnt_t RST_S = 24'h005dc0, RSM_S = 24'h0000c8, GAP_S = 24'h000032, DCH_S = 24'h00012c;
  localparam ubet_cnt_t WTFS_S = 24'h000258, SUSP_S = 24'h000190, WTRSM_S = 24'h0001f4;
  ubet_line_e upLine;
  int error_cnt, checks_done, n, m;
  ubet_link_if link();
  ubet_hub_end #(.P_RSMDN(RSM_S), .P_RST(RST_S), .P_ROOT_GAP(GAP_S)) ubet_hub_end_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .link(link.hub), .portReset(portReset), .resumeReq(resumeReq),
    .rootHub(rootHub), .resetActive(resetActive), .hsMode(hHs), .connected(connected), .discEvt(discEvt),
    .rsmRebroadcast(rsmRb), .upLine(upLine), .eof1(eof1), .eofSe0En(eofSe0En), .longK(longK), .longSe0(longSe0),
    .upSe0Rep(upSe0Rep), .upSe0Eof(upSe0Eof), .txReq(hTxReq), .txActive(hTxAct), .txGo(hTxGo), .respLate());
  ubet_dev_end #(.P_DCHIRP(DCH_S), .P_WTFS(WTFS_S), .P_SUSP(SUSP_S), .P_WTRSM(WTRSM_S),
    .P_DRSMUP(RSM_S)) ubet_dev_end_inst (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .link(link.dev),
    .powerGood(powerGood), .hsCap(hsCap), .rwEn(rwEn), .wakeReq(wakeReq), .captive(captive), .attached(attached),
    .suspend(suspend), .resetSeen(resetSeen), .hsMode(dHs), .resuming(resuming), .txReq(dTxReq),
    .txActive(dTxAct), .txGo(), .respLate(dLate));
  ubet_link_sva #(.P_RST(RST_S), .P_RSMDN(RSM_S)) ubet_link_sva_inst (.clk_sys(clk_sys),
    .arst_n(arst_n), .hubLine(link.hubLine), .hubLineOe_n(link.hubLineOe_n), .devLine(link.devLine),
    .devLineOe_n(link.devLineOe_n), .devAttach(link.devAttach));
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic s_attach();
    powerGood = 1'b1;
    for (n = 0; n < 150 && !connected; n++) step(1);
    chk("connect", n inside {[99:105]}, 24'h000001);
    chk("attach", attached, 24'h000001);
    for (n = 0; n < 600 && !suspend; n++) step(1);
    chk("suspend", n inside {[250:400]}, 24'h000001);
  endtask : s_attach
  task automatic s_reset();
    hsCap = 1'b1;
    portReset = 1'b1;
    step(1);
    portReset = 1'b0;
    for (n = 0; n < 200 && !resetSeen; n++) step(1);
    chk("rst seen", n inside {[95:105]}, 24'h000001);
    for (m = n; m < 25000 && resetActive; m++) step(1);
    chk("rst len", m inside {[23990:24001]}, 24'h000001);
    chk("hub hs", hHs, 24'h000001);
    chk("dev hs", dHs, 24'h000001);
  endtask : s_reset
  task automatic s_resume();
    resumeReq = 1'b1;
    step(1);
    resumeReq = 1'b0;
    step(2);
    chk("rsm k", link.busLine, LINE_K);
    step(190);
    chk("rsm hold", link.busLine, LINE_K);
    step(15);
    chk("rsm end", link.busLine, LINE_J);
  endtask : s_resume
  task automatic s_wake();
    rwEn = 1'b1;
    wakeReq = 1'b1;
    step(100);
    chk("early wake", resuming, 24'h000000);
    for (n = 0; n < 600 && !resuming; n++) step(1);
    chk("wake", resuming, 24'h000001);
    wakeReq = 1'b0;
    for (n = 0; n < 150 && !rsmRb; n++) step(1);
    chk("rebroadcast", n inside {[95:105]}, 24'h000001);
    for (n = 0; n < 300 && resuming; n++) step(1);
    chk("wake len", n inside {[90:110]}, 24'h000001);
  endtask : s_wake
  task automatic s_gap();
    hTxAct = 1'b1;
    step(3);
    hTxAct = 1'b0;
    hTxReq = 1'b1;
    for (n = 0; n < 30 && !hTxGo; n++) step(1);
    chk("same gap", n inside {[7:9]}, 24'h000001);
    for (m = n; m < 30 && !dLate; m++) step(1);
    chk("late", m inside {[13:17]}, 24'h000001);
    dTxAct = 1'b1;
    step(2);
    chk("busy", hTxGo, 24'h000000);
    dTxAct = 1'b0;
    step(2);
    chk("opp gap", hTxGo, 24'h000001);
    hTxReq = 1'b0;
  endtask : s_gap
  task automatic s_up();
    upLine = LINE_K;
    step(60);
    upLine = LINE_J;
    step(1);
    upLine = LINE_K;
    step(98);
    chk("k restart", longK, 24'h000000);
    step(4);
    chk("long k", longK, 24'h000001);
    upLine = LINE_SE0;
    step(102);
    chk("long se0", longSe0, 24'h000001);
    upLine = LINE_J;
    eofSe0En = 1'b1;
    eof1 = 1'b1;
    step(1);
    eof1 = 1'b0;
    m = 0;
    for (n = 0; n < 10; n++) begin
      m += upSe0Eof;
      step(1);
    end
    chk("eof se0", m, 24'h000006);
  endtask : s_up
  task automatic s_disc();
    powerGood = 1'b0;
    step(3);
    chk("rep se0", upSe0Rep, 24'h000001);
    for (n = 0; n < 120 && !discEvt; n++) step(1);
    chk("disc", n inside {[74:80]}, 24'h000001);
    chk("conn off", connected, 24'h000000);
    step(5);
    chk("rep cut", upSe0Rep, 24'h000000);
  endtask : s_disc
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    {portReset, resumeReq, eof1, eofSe0En, hTxReq, hTxAct, powerGood, hsCap, rwEn, wakeReq, dTxAct} = '0;
    {rootHub, captive, dTxReq} = '0;
    ce = 1'b1;
    upLine = LINE_J;
    error_cnt = 0;
    checks_done = 0;
    arst_n = 1'b0;
    step(2);
    arst_n = 1'b1;
    s_attach();
    s_reset();
    s_resume();
    s_wake();
    s_gap();
    s_up();
    s_disc();
    finish_test();
  end
  initial begin
    #2000000;
    chk("timeout", 24'h000000, 24'h000001);
    finish_test();
  end
endmodule : usb_bus_event_timers_tb
